/* File: src/bridge_txn_defs.vh */
// command codes, address-type codes and decode constants of the bridge transaction front end
`ifndef BRIDGE_TXN_DEFS_VH
`define BRIDGE_TXN_DEFS_VH

// ****************************************************************
// bus command codes (complement of C/BE# during an address phase)
// ****************************************************************
`define CMD_INT_ACK   4'h0
`define CMD_SPECIAL   4'h1
`define CMD_IO_RD     4'h2
`define CMD_IO_WR     4'h3
`define CMD_RSV_4     4'h4
`define CMD_RSV_5     4'h5
`define CMD_MEM_RD    4'h6
`define CMD_MEM_WR    4'h7
`define CMD_RSV_8     4'h8
`define CMD_RSV_9     4'h9
`define CMD_CFG_RD    4'hA
`define CMD_CFG_WR    4'hB
`define CMD_MEM_RD_MUL 4'hC
`define CMD_DUAL_ADDR 4'hD
`define CMD_MEM_RD_LN 4'hE
`define CMD_MEM_WR_INV 4'hF

// ****************************************************************
// address low bits, configuration bus number field, zero upper half
// ****************************************************************
`define CFG_TYPE0     2'h0
`define CFG_TYPE1     2'h1
`define ADDR_LINEAR   2'h0
`define CFG_BUS_LSB   16
`define CFG_BUS_MSB   23
`define UPPER_ZERO    32'h00000000

// ****************************************************************
// side indices
// ****************************************************************
`define SIDE_PRI      0
`define SIDE_SEC      1
`define SIDE_COUNT    2

`endif

/* File: src/bus_phase_track.v */
// phase tracker for one bus: frame start, data phase completion, transfer, last phase
`timescale 1ns/1ps

module bus_phase_track (
  input  wire bus_clk_i,
  input  wire reset_n_i,
  input  wire frame_n_i,
  input  wire irdy_n_i,
  input  wire trdy_n_i,
  input  wire stop_n_i,
  output wire start_o,
  output wire done_o,
  output wire xfer_o,
  output wire last_o
);

  // ****************************************************************
  // previous-cycle bus state
  // ****************************************************************
  reg frame_n_r;
  reg irdy_n_r;

  always @(posedge bus_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_n_r <= 1'b1;
      irdy_n_r  <= 1'b1;
    end else begin
      frame_n_r <= frame_n_i;
      irdy_n_r  <= irdy_n_i;
    end
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  // first address phase: FRAME# falls out of an idle bus
  assign start_o = !frame_n_i && frame_n_r && irdy_n_r;
  assign done_o  = !irdy_n_i && (!trdy_n_i || !stop_n_i);
  assign xfer_o  = !irdy_n_i && !trdy_n_i;
  assign last_o  = (frame_n_i && !irdy_n_i && !trdy_n_i) ||
                   (!irdy_n_i && !stop_n_i);

endmodule // bus_phase_track

/* File: src/pci_bridge_txn_decode.v */
// transaction front end of a two-bus bridge: target claim, medium DEVSEL#, phase tracking
// Function
// - memory read line and write-and-invalidate codes are forwarded both ways.
// - never start a reserved command; never claim a reserved command.
// - never start or claim an interrupt acknowledge cycle.
// - special cycles never claimed; type 1 configuration carries them instead.
// - no type 0 configuration started on primary, none claimed on secondary.
// - one clock per address phase; first one where FRAME# goes asserted.
// - nonlinear low address bits: disconnect after the first data transfer.
// - dual address: low half plus DAC, next clock high half plus command.
// - dual address always upstream; downstream only inside the prefetchable window.
// - second dual-address command must be a memory command, else unclaimed.
// - claim only by positive decode, never subtractive.
// - claimed cycles get DEVSEL# with medium timing.
// - phase ends on IRDY# with TRDY# or STOP#; data moves on IRDY# and TRDY#.
// - last phase: FRAME# high with IRDY# and TRDY#, or IRDY# with STOP#.
`timescale 1ns/1ps
`include "bridge_txn_defs.vh"

module pci_bridge_txn_decode (
  input  wire        clk_i,
  input  wire        s_clk_i,
  input  wire        reset_n_i,
  // primary bus pins
  input  wire        p_frame_n_i,
  input  wire        p_irdy_n_i,
  input  wire        p_trdy_n_i,
  input  wire        p_stop_n_i,
  input  wire [31:0] p_ad_i,
  input  wire [3:0]  p_cbe_n_i,
  output wire        p_devsel_n_o,
  output wire        p_devsel_oe_o,
  output wire        p_stop_n_o,
  output wire        p_stop_oe_o,
  // secondary bus pins
  input  wire        s_frame_n_i,
  input  wire        s_irdy_n_i,
  input  wire        s_trdy_n_i,
  input  wire        s_stop_n_i,
  input  wire [31:0] s_ad_i,
  input  wire [3:0]  s_cbe_n_i,
  output wire        s_devsel_n_o,
  output wire        s_devsel_oe_o,
  output wire        s_stop_n_o,
  output wire        s_stop_oe_o,
  // decode windows, static while the bus is active
  input  wire [31:0] io_base_i,
  input  wire [31:0] io_limit_i,
  input  wire [31:0] mem_base_i,
  input  wire [31:0] mem_limit_i,
  input  wire [63:0] pf_base_i,
  input  wire [63:0] pf_limit_i,
  input  wire [7:0]  sec_bus_i,
  input  wire [7:0]  sub_bus_i,
  // claimed transaction reports, per bus clock
  output wire        p_claim_o,
  output wire [3:0]  p_fwd_cmd_o,
  output wire [63:0] p_fwd_addr_o,
  output wire        p_fwd_dual_o,
  output wire        p_xfer_o,
  output wire        p_done_o,
  output wire        p_last_o,
  output wire        s_claim_o,
  output wire [3:0]  s_fwd_cmd_o,
  output wire [63:0] s_fwd_addr_o,
  output wire        s_fwd_dual_o,
  output wire        s_xfer_o,
  output wire        s_done_o,
  output wire        s_last_o,
  // initiator command check, per bus
  input  wire        p_mst_req_i,
  input  wire [3:0]  p_mst_cmd_i,
  input  wire [1:0]  p_mst_ad_i,
  output wire        p_mst_go_o,
  output wire        p_mst_refuse_o,
  input  wire        s_mst_req_i,
  input  wire [3:0]  s_mst_cmd_i,
  input  wire [1:0]  s_mst_ad_i,
  output wire        s_mst_go_o,
  output wire        s_mst_refuse_o
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADR2 = 3'h1;
  localparam [2:0] ST_DEC  = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_TAR  = 3'h4;

  // ****************************************************************
  // per-side pin bundles
  // ****************************************************************
  wire [1:0]  bus_clk   = {s_clk_i, clk_i};
  wire [1:0]  frame_n   = {s_frame_n_i, p_frame_n_i};
  wire [1:0]  irdy_n    = {s_irdy_n_i, p_irdy_n_i};
  wire [1:0]  trdy_n    = {s_trdy_n_i, p_trdy_n_i};
  wire [1:0]  stop_n    = {s_stop_n_i, p_stop_n_i};
  wire [63:0] ad_all    = {s_ad_i, p_ad_i};
  wire [7:0]  cbe_all   = {s_cbe_n_i, p_cbe_n_i};
  wire [1:0]  mst_req   = {s_mst_req_i, p_mst_req_i};
  wire [7:0]  mst_cmd   = {s_mst_cmd_i, p_mst_cmd_i};
  wire [3:0]  mst_ad    = {s_mst_ad_i, p_mst_ad_i};

  wire [1:0]   devsel_n;
  wire [1:0]   devsel_oe;
  wire [1:0]   stp_n;
  wire [1:0]   stp_oe;
  wire [1:0]   claim;
  wire [7:0]   fwd_cmd;
  wire [127:0] fwd_addr;
  wire [1:0]   fwd_dual;
  wire [1:0]   xfer_out;
  wire [1:0]   done_out;
  wire [1:0]   last_out;
  wire [1:0]   mst_go;
  wire [1:0]   mst_refuse;

  // ****************************************************************
  // command class helpers
  // ****************************************************************
  function is_mem;
    input [3:0] cmd;
    begin
      is_mem = (cmd == `CMD_MEM_RD) || (cmd == `CMD_MEM_WR) ||
               (cmd == `CMD_MEM_RD_MUL) ||
               (cmd == `CMD_MEM_RD_LN) || (cmd == `CMD_MEM_WR_INV);
    end
  endfunction

  function is_io;
    input [3:0] cmd;
    begin
      is_io = (cmd == `CMD_IO_RD) || (cmd == `CMD_IO_WR);
    end
  endfunction

  function is_cfg;
    input [3:0] cmd;
    begin
      is_cfg = (cmd == `CMD_CFG_RD) || (cmd == `CMD_CFG_WR);
    end
  endfunction

  // ****************************************************************
  // per-side logic
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `SIDE_COUNT; g = g + 1) begin : side
      wire        start;
      wire        done;
      wire        xfer;
      wire        last;
      wire [31:0] ad    = ad_all[32*g+31:32*g];
      wire [3:0]  cmd_i = ~cbe_all[4*g+3:4*g];

      bus_phase_track u_track (
        .bus_clk_i (bus_clk[g]),
        .reset_n_i (reset_n_i),
        .frame_n_i (frame_n[g]),
        .irdy_n_i  (irdy_n[g]),
        .trdy_n_i  (trdy_n[g]),
        .stop_n_i  (stop_n[g]),
        .start_o   (start),
        .done_o    (done),
        .xfer_o    (xfer),
        .last_o    (last)
      );

      reg [2:0]  state_r;
      reg [2:0]  state_nxt;
      reg [31:0] addr_lo_r;
      reg [31:0] addr_hi_r;
      reg [3:0]  cmd_r;
      reg        dual_r;
      reg        devsel_r;
      reg        devsel_oe_r;
      reg        stop_r;
      reg        stop_oe_r;
      reg        xfer_r;
      reg        done_r;
      reg        last_r;

      // ---- positive decode against the windows; no default claim
      wire [63:0] addr64 = {addr_hi_r, addr_lo_r};
      wire [7:0]  cfg_bus = addr_lo_r[`CFG_BUS_MSB:`CFG_BUS_LSB];
      wire in_io  = (addr_lo_r >= io_base_i) && (addr_lo_r <= io_limit_i);
      wire in_m32 = (addr_lo_r >= mem_base_i) && (addr_lo_r <= mem_limit_i);
      wire in_pf  = (addr64 >= pf_base_i) && (addr64 <= pf_limit_i);
      wire in_bus = (cfg_bus >= sec_bus_i) && (cfg_bus <= sub_bus_i);
      wire is_t1  = addr_lo_r[1:0] == `CFG_TYPE1;
      reg  hit;

      always @* begin
        hit = 1'b0;
        if (dual_r) begin
          // second phase must carry a memory command
          if (is_mem(cmd_r)) begin
            hit = (g == `SIDE_PRI) ? in_pf : 1'b1;
          end
        end else if (is_mem(cmd_r)) begin
          hit = (g == `SIDE_PRI) ? (in_m32 || in_pf) : !(in_m32 || in_pf);
        end else if (is_io(cmd_r)) begin
          hit = (g == `SIDE_PRI) ? in_io : !in_io;
        end else if (is_cfg(cmd_r)) begin
          // type 0 below the bridge is never ours to take
          hit = is_t1 && ((g == `SIDE_PRI) ? in_bus : !in_bus);
        end
        // reserved, interrupt acknowledge, special cycle stay unclaimed
      end

      wire misaligned = is_mem(cmd_r) && (addr_lo_r[1:0] != `ADDR_LINEAR);

      always @* begin
        state_nxt = state_r;
        case (state_r)
          ST_IDLE: begin
            if (start) begin
              state_nxt = (cmd_i == `CMD_DUAL_ADDR) ? ST_ADR2 : ST_DEC;
            end
          end
          ST_ADR2: begin
            state_nxt = ST_DEC;
          end
          ST_DEC: begin
            state_nxt = hit ? ST_DATA : ST_IDLE;
          end
          ST_DATA: begin
            if (done && last) begin
              state_nxt = ST_TAR;
            end
          end
          ST_TAR: begin
            state_nxt = ST_IDLE;
          end
          default: begin
            state_nxt = ST_IDLE;
          end
        endcase
      end

      always @(posedge bus_clk[g] or negedge reset_n_i) begin
        if (!reset_n_i) begin
          state_r     <= ST_IDLE;
          addr_lo_r   <= 32'h00000000;
          addr_hi_r   <= 32'h00000000;
          cmd_r       <= 4'h0;
          dual_r      <= 1'b0;
          devsel_r    <= 1'b0;
          devsel_oe_r <= 1'b0;
          stop_r      <= 1'b0;
          stop_oe_r   <= 1'b0;
          xfer_r      <= 1'b0;
          done_r      <= 1'b0;
          last_r      <= 1'b0;
        end else begin
          state_r <= state_nxt;
          xfer_r  <= xfer;
          done_r  <= done;
          last_r  <= last;
          if (state_r == ST_IDLE && start) begin
            addr_lo_r <= ad;
            addr_hi_r <= `UPPER_ZERO;
            cmd_r     <= cmd_i;
            dual_r    <= cmd_i == `CMD_DUAL_ADDR;
          end
          if (state_r == ST_ADR2) begin
            // the clock right after the first phase holds high half and command
            addr_hi_r <= ad;
            cmd_r     <= cmd_i;
          end
          // driven one clock after decode: seen on the second clock, medium timing
          if (state_r == ST_DEC && hit) begin
            devsel_r    <= 1'b1;
            devsel_oe_r <= 1'b1;
          end
          if (state_r == ST_DATA && xfer && misaligned && !(done && last)) begin
            stop_r    <= 1'b1;
            stop_oe_r <= 1'b1;
          end
          if (state_r == ST_DATA && done && last) begin
            // deasserted high one clock before release
            devsel_r <= 1'b0;
            stop_r   <= 1'b0;
          end
          if (state_r == ST_TAR) begin
            devsel_oe_r <= 1'b0;
            stop_oe_r   <= 1'b0;
          end
        end
      end

      // ---- initiator check: only legal commands leave the bridge
      wire [3:0] mc = mst_cmd[4*g+3:4*g];
      wire mst_ok = is_mem(mc) || is_io(mc) ||
                    (mc == `CMD_DUAL_ADDR) ||
                    (is_cfg(mc) && !(g == `SIDE_PRI &&
                      mst_ad[2*g+1:2*g] == `CFG_TYPE0)) ||
                    (mc == `CMD_SPECIAL && g == `SIDE_SEC);
      // reserved and interrupt acknowledge never pass
      assign mst_go[g]     = mst_req[g] && mst_ok;
      assign mst_refuse[g] = mst_req[g] && !mst_ok;

      assign devsel_n[g]            = !devsel_r;
      assign devsel_oe[g]           = devsel_oe_r;
      assign stp_n[g]               = !stop_r;
      assign stp_oe[g]              = stop_oe_r;
      assign claim[g]               = devsel_r;
      assign fwd_cmd[4*g+3:4*g]     = cmd_r;
      assign fwd_addr[64*g+63:64*g] = addr64;
      assign fwd_dual[g]            = dual_r;
      assign xfer_out[g]            = xfer_r;
      assign done_out[g]            = done_r;
      assign last_out[g]            = last_r;
    end
  endgenerate

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign p_devsel_n_o   = devsel_n[0];
  assign p_devsel_oe_o  = devsel_oe[0];
  assign p_stop_n_o     = stp_n[0];
  assign p_stop_oe_o    = stp_oe[0];
  assign s_devsel_n_o   = devsel_n[1];
  assign s_devsel_oe_o  = devsel_oe[1];
  assign s_stop_n_o     = stp_n[1];
  assign s_stop_oe_o    = stp_oe[1];
  assign p_claim_o      = claim[0];
  assign p_fwd_cmd_o    = fwd_cmd[3:0];
  assign p_fwd_addr_o   = fwd_addr[63:0];
  assign p_fwd_dual_o   = fwd_dual[0];
  assign p_xfer_o       = xfer_out[0];
  assign p_done_o       = done_out[0];
  assign p_last_o       = last_out[0];
  assign s_claim_o      = claim[1];
  assign s_fwd_cmd_o    = fwd_cmd[7:4];
  assign s_fwd_addr_o   = fwd_addr[127:64];
  assign s_fwd_dual_o   = fwd_dual[1];
  assign s_xfer_o       = xfer_out[1];
  assign s_done_o       = done_out[1];
  assign s_last_o       = last_out[1];
  assign p_mst_go_o     = mst_go[0];
  assign p_mst_refuse_o = mst_refuse[0];
  assign s_mst_go_o     = mst_go[1];
  assign s_mst_refuse_o = mst_refuse[1];

endmodule // pci_bridge_txn_decode

/* File: testbench/txn_decode_assertions.sv */
// checker of the bridge transaction front end, bound to its top
`timescale 1ns/1ps
module txn_decode_checker (
  input wire        clk_i,
  input wire        s_clk_i,
  input wire        reset_n_i,
  input wire        p_frame_n_i,
  input wire        p_irdy_n_i,
  input wire        p_trdy_n_i,
  input wire        p_stop_n_i,
  input wire [3:0]  p_cbe_n_i,
  input wire        p_devsel_n_o,
  input wire        p_xfer_o,
  input wire        p_last_o,
  input wire        p_done_o,
  input wire        p_claim_o,
  input wire        p_mst_req_i,
  input wire [3:0]  p_mst_cmd_i,
  input wire        p_mst_refuse_o,
  input wire        s_frame_n_i,
  input wire        s_irdy_n_i,
  input wire        s_trdy_n_i,
  input wire        s_stop_n_i,
  input wire [31:0] s_ad_i,
  input wire [3:0]  s_cbe_n_i,
  input wire        s_devsel_n_o,
  input wire        s_done_o,
  input wire        s_xfer_o,
  input wire        s_last_o
);
  // ****
  // primary bus
  // ****
  no_fast_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(p_frame_n_i) |=> p_devsel_n_o) else $error("devsel too early");
  not_slow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(p_frame_n_i) && p_cbe_n_i != 4'h2 ##3 !p_devsel_n_o |-> !$past(p_devsel_n_o))
    else $error("devsel too late");
  rsv_unclaimed_a: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) $fell(p_frame_n_i) &&
    p_cbe_n_i inside {4'hF, 4'hE, 4'hB, 4'hA, 4'h7, 4'h6}
    |-> p_devsel_n_o [*4]) else $error("ignored command claimed");
  xfer_echo_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    p_xfer_o == $past(!p_irdy_n_i && !p_trdy_n_i) &&
    p_done_o == $past(!p_irdy_n_i && (!p_trdy_n_i || !p_stop_n_i)))
    else $error("transfer flag wrong");
  last_echo_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    p_last_o == $past(!p_irdy_n_i && ((p_frame_n_i && !p_trdy_n_i) || !p_stop_n_i)))
    else $error("last flag wrong");
  devsel_release_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !p_devsel_n_o && !p_irdy_n_i && !p_stop_n_i |=> p_devsel_n_o)
    else $error("devsel held past last phase");
  claim_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(p_frame_n_i) && p_cbe_n_i == 4'h9 ##2 !p_devsel_n_o |-> p_claim_o)
    else $error("claim flag missing");
  mst_refuse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    p_mst_req_i && p_mst_cmd_i inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9} |-> p_mst_refuse_o)
    else $error("bad command not refused");
  // ****
  // secondary bus
  // ****
  sec_type0_a: assert property (@(posedge s_clk_i) disable iff (!reset_n_i)
    $fell(s_frame_n_i) && s_cbe_n_i[3:1] == 3'b010 && s_ad_i[1:0] == 2'b00
    |-> s_devsel_n_o [*4]) else $error("type 0 claimed on secondary");
  dual_late_a: assert property (@(posedge s_clk_i) disable iff (!reset_n_i)
    $fell(s_frame_n_i) && s_cbe_n_i == 4'h2 |-> ##2 s_devsel_n_o)
    else $error("dual cycle claimed before second phase");
  done_echo_a: assert property (@(posedge s_clk_i) disable iff (!reset_n_i)
    s_done_o == $past(!s_irdy_n_i && (!s_trdy_n_i || !s_stop_n_i)) &&
    s_xfer_o == $past(!s_irdy_n_i && !s_trdy_n_i) &&
    s_last_o == $past(!s_irdy_n_i && ((s_frame_n_i && !s_trdy_n_i) || !s_stop_n_i)))
    else $error("secondary phase flag wrong");
endmodule // txn_decode_checker

bind pci_bridge_txn_decode txn_decode_checker chk (.clk_i, .s_clk_i, .reset_n_i,
  .p_frame_n_i, .p_irdy_n_i, .p_trdy_n_i, .p_stop_n_i, .p_cbe_n_i, .p_devsel_n_o,
  .p_xfer_o, .p_last_o, .p_done_o, .p_claim_o, .p_mst_req_i, .p_mst_cmd_i,
  .p_mst_refuse_o, .s_frame_n_i, .s_irdy_n_i, .s_trdy_n_i, .s_stop_n_i, .s_ad_i,
  .s_cbe_n_i, .s_devsel_n_o, .s_done_o, .s_xfer_o, .s_last_o);

/* File: testbench/pci_agent_model.sv */
// bus agent: initiator plus data-path target handshake on one bus
`timescale 1ns/1ps
module pci_agent_model (
  input  wire        bus_clk_i,
  input  wire        devsel_n_i,
  input  wire        stop_n_i,
  output reg         frame_n_o,
  output reg         irdy_n_o,
  output reg         trdy_n_o,
  output reg  [31:0] ad_o,
  output reg  [3:0]  cbe_n_o
);
  integer dev_at;
  reg     stop_seen;
  initial begin
    frame_n_o = 1'b1; irdy_n_o = 1'b1; trdy_n_o = 1'b1;
    ad_o = 32'h0; cbe_n_o = 4'hF; dev_at = 15; stop_seen = 1'b0;
  end
  // ****
  // one transaction; dev_at is the edge from E0 where devsel was seen, 15 for never
  // ****
  task txn(input [3:0] c1, input [3:0] c2, input [63:0] a, input du, input two);
    integer e;
    reg     fin;
    reg     dn;
    begin
      dev_at = 15; stop_seen = 1'b0; fin = 1'b0; e = 0;
      @(negedge bus_clk_i);
      frame_n_o = 1'b0; ad_o = a[31:0]; cbe_n_o = ~c1;
      if (du) begin
        @(negedge bus_clk_i);
        ad_o = a[63:32]; cbe_n_o = ~c2;
        e = 1;
      end
      @(negedge bus_clk_i);
      irdy_n_o = 1'b0; frame_n_o = ~two; ad_o = 32'hA5A50000; cbe_n_o = 4'h0;
      while (!fin) begin
        @(posedge bus_clk_i);
        e = e + 1;
        if (!devsel_n_i && dev_at == 15) dev_at = e;
        if (!stop_n_i) stop_seen = 1'b1;
        dn = !irdy_n_o && (!trdy_n_o || !stop_n_i);
        fin = (dn && (frame_n_o || !stop_n_i)) || (e > 5 && frame_n_o);
        @(negedge bus_clk_i);
        // no more data once disconnect is signalled
        if (!fin) trdy_n_o = !(dev_at != 15 && stop_n_i);
        // no claim by edge 5: master abort
        if (dn || e > 4) frame_n_o = 1'b1;
      end
      // released lines show a changed value, not the last one
      irdy_n_o = 1'b1; trdy_n_o = 1'b1; ad_o = ~ad_o; cbe_n_o = ~cbe_n_o;
      @(negedge bus_clk_i);
      @(negedge bus_clk_i);
    end
  endtask
endmodule // pci_agent_model

/* File: testbench/tb.sv */
// top-level testbench of the bridge transaction front end
`timescale 1ns/1ps
module tb;
  // ****
  // clocks, pins and the device
  // ****
  reg          clk_i, s_clk_i, reset_n_i, p_mreq, s_mreq;
  reg   [3:0]  p_mcmd, s_mcmd;
  reg   [1:0]  p_mad, s_mad;
  reg   [31:0] io_lo, io_hi, mem_lo, mem_hi;
  reg   [63:0] pf_lo, pf_hi;
  reg   [7:0]  bus_lo, bus_hi;
  wire         p_frame, p_irdy, p_trdy, s_frame, s_irdy, s_trdy;
  wire  [31:0] p_ad, s_ad;
  wire  [3:0]  p_cbe, s_cbe, p_fcmd, s_fcmd;
  wire  [63:0] p_faddr, s_faddr;
  wire         p_dn, p_doe, p_sn, p_soe, s_dn, s_doe, s_sn, s_soe;
  wire         p_claim, p_fdual, p_go, p_ref, s_claim, s_fdual, s_go, s_ref;
  integer      num_errors, total_checks;
  // control lines are pulled up when nobody drives them
  wire         p_devsel = p_doe ? p_dn : 1'b1;
  wire         p_stop   = p_soe ? p_sn : 1'b1;
  wire         s_devsel = s_doe ? s_dn : 1'b1;
  wire         s_stop   = s_soe ? s_sn : 1'b1;

  always #5 clk_i = ~clk_i;
  // unrelated secondary rate keeps the phases drifting
  always #6 s_clk_i = ~s_clk_i;

  pci_bridge_txn_decode dut (.clk_i(clk_i), .s_clk_i(s_clk_i), .reset_n_i(reset_n_i),
    .p_frame_n_i(p_frame), .p_irdy_n_i(p_irdy), .p_trdy_n_i(p_trdy), .p_stop_n_i(p_stop),
    .p_ad_i(p_ad), .p_cbe_n_i(p_cbe), .p_devsel_n_o(p_dn), .p_devsel_oe_o(p_doe),
    .p_stop_n_o(p_sn), .p_stop_oe_o(p_soe), .s_frame_n_i(s_frame), .s_irdy_n_i(s_irdy),
    .s_trdy_n_i(s_trdy), .s_stop_n_i(s_stop), .s_ad_i(s_ad), .s_cbe_n_i(s_cbe),
    .s_devsel_n_o(s_dn), .s_devsel_oe_o(s_doe), .s_stop_n_o(s_sn), .s_stop_oe_o(s_soe),
    .io_base_i(io_lo), .io_limit_i(io_hi), .mem_base_i(mem_lo), .mem_limit_i(mem_hi),
    .pf_base_i(pf_lo), .pf_limit_i(pf_hi), .sec_bus_i(bus_lo), .sub_bus_i(bus_hi),
    .p_claim_o(p_claim), .p_fwd_cmd_o(p_fcmd), .p_fwd_addr_o(p_faddr),
    .p_fwd_dual_o(p_fdual), .p_xfer_o(), .p_done_o(), .p_last_o(),
    .s_claim_o(s_claim), .s_fwd_cmd_o(s_fcmd), .s_fwd_addr_o(s_faddr),
    .s_fwd_dual_o(s_fdual), .s_xfer_o(), .s_done_o(), .s_last_o(),
    .p_mst_req_i(p_mreq), .p_mst_cmd_i(p_mcmd), .p_mst_ad_i(p_mad), .p_mst_go_o(p_go),
    .p_mst_refuse_o(p_ref), .s_mst_req_i(s_mreq), .s_mst_cmd_i(s_mcmd),
    .s_mst_ad_i(s_mad), .s_mst_go_o(s_go), .s_mst_refuse_o(s_ref));

  pci_agent_model p_agent (.bus_clk_i(clk_i), .devsel_n_i(p_devsel), .stop_n_i(p_stop),
    .frame_n_o(p_frame), .irdy_n_o(p_irdy), .trdy_n_o(p_trdy), .ad_o(p_ad), .cbe_n_o(p_cbe));
  pci_agent_model s_agent (.bus_clk_i(s_clk_i), .devsel_n_i(s_devsel), .stop_n_i(s_stop),
    .frame_n_o(s_frame), .irdy_n_o(s_irdy), .trdy_n_o(s_trdy), .ad_o(s_ad), .cbe_n_o(s_cbe));

  // ****
  // compares and shared transaction
  // ****
  task chk_bit(input string what, input logic exp, input logic got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task run(input sd, input [3:0] c1, input [3:0] c2, input [63:0] a, input du, input two,
           input [63:0] ed, input es);
    begin
      if (sd) begin
        s_agent.txn(c1, c2, a, du, two);
        chk_val("s devsel edge", ed, s_agent.dev_at);
        chk_bit("s stop seen", es, s_agent.stop_seen);
      end else begin
        p_agent.txn(c1, c2, a, du, two);
        chk_val("p devsel edge", ed, p_agent.dev_at);
        chk_bit("p stop seen", es, p_agent.stop_seen);
      end
    end
  endtask
  // ****
  // scenarios
  // ****
  task test_claims;
    integer c;
    reg     hit;
    begin
      for (c = 0; c < 16; c = c + 1) begin
        hit = (c == 2) || (c == 3) || (c == 6) || (c == 7) || (c >= 12);
        if (c != 13) begin
          run(1'b0, c[3:0], 4'h0, 64'h10000000, 1'b0, 1'b0,
            hit ? 2 : 15, 1'b0);
          run(1'b1, c[3:0], 4'h0, 64'h30000000, 1'b0, 1'b0,
            hit ? 2 : 15, 1'b0);
        end
      end
      run(1'b0, 4'h6, 4'h0, 64'h30000000, 1'b0, 1'b0, 64'hF, 1'b0);
      run(1'b1, 4'h6, 4'h0, 64'h10000000, 1'b0, 1'b0, 64'hF, 1'b0);
      run(1'b0, 4'hA, 4'h0, 64'h00050001, 1'b0, 1'b0, 64'h2, 1'b0);
      run(1'b0, 4'hB, 4'h0, 64'h00090001, 1'b0, 1'b0, 64'hF, 1'b0);
      $display("test claims done");
    end
  endtask
  task test_dual;
    integer c;
    reg     hit;
    begin
      run(1'b0, 4'hD, 4'h6, 64'h0000000120000000, 1'b1, 1'b0, 64'h3, 1'b0);
      chk_bit("p dual flag", 1'b1, p_fdual);
      chk_val("p dual addr", 64'h0000000120000000, p_faddr);
      chk_val("p dual cmd", 64'h6, {60'h0, p_fcmd});
      run(1'b0, 4'hD, 4'h7, 64'h0000000220000000, 1'b1, 1'b0, 64'hF, 1'b0);
      for (c = 0; c < 16; c = c + 1) begin
        hit = (c == 6) || (c == 7) || (c == 12) || (c >= 14);
        run(1'b1, 4'hD, c[3:0], 64'h0000000220000000, 1'b1, 1'b0,
          hit ? 3 : 15, 1'b0);
        chk_val("s dual cmd", c, {60'h0, s_fcmd});
        chk_bit("s dual flag", 1'b1, s_fdual);
        chk_val("s dual addr", 64'h0000000220000000, s_faddr);
      end
      $display("test dual done");
    end
  endtask
  task test_disc;
    begin
      run(1'b0, 4'h6, 4'h0, 64'h10000001, 1'b0, 1'b1, 64'h2, 1'b1);
      run(1'b0, 4'hE, 4'h0, 64'h10000000, 1'b0, 1'b1, 64'h2, 1'b0);
      run(1'b1, 4'h7, 4'h0, 64'h30000002, 1'b0, 1'b1, 64'h2, 1'b1);
      $display("test disconnect done");
    end
  endtask
  task test_mst;
    integer k;
    reg     rp;
    reg     rs;
    begin
      for (k = 0; k < 32; k = k + 1) begin
        @(negedge clk_i);
        p_mreq = 1'b1; s_mreq = 1'b1; p_mcmd = k[3:0]; s_mcmd = k[3:0];
        p_mad = {1'b0, k[4]}; s_mad = {1'b0, k[4]};
        rs = (k[3:0] == 0) || (k[3:0] == 4) || (k[3:0] == 5) || (k[3:0] == 8) || (k[3:0] == 9);
        rp = rs || (k[3:0] == 1) || (k[3:1] == 3'b101 && !k[4]);
        #1;
        chk_bit("p refuse", rp, p_ref);
        chk_bit("p go", !rp, p_go);
        chk_bit("s refuse", rs, s_ref);
        chk_bit("s go", !rs, s_go);
      end
      @(negedge clk_i);
      p_mreq = 1'b0; s_mreq = 1'b0;
      $display("test initiator check done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  initial begin
    clk_i = 1'b0; s_clk_i = 1'b0; reset_n_i = 1'b0; num_errors = 0; total_checks = 0;
    p_mreq = 1'b0; s_mreq = 1'b0; p_mcmd = 4'h0; s_mcmd = 4'h0; p_mad = 2'h0; s_mad = 2'h0;
    io_lo = 32'h10000000; io_hi = 32'h1FFFFFFF; mem_lo = 32'h10000000; mem_hi = 32'h1FFFFFFF;
    pf_lo = 64'h0000000100000000; pf_hi = 64'h00000001FFFFFFFF; bus_lo = 8'h05; bus_hi = 8'h05;
    @(negedge clk_i);
    chk_bit("p devsel oe in reset", 1'b0, p_doe);
    chk_bit("s devsel oe in reset", 1'b0, s_doe);
    chk_val("p fwd addr in reset", 64'h0, p_faddr);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge s_clk_i);
    test_claims;
    test_dual;
    test_disc;
    test_mst;
    give_verdict;
  end

  // 55 transactions of under 15 slow clocks each, with wide margin
  initial begin
    #300000;
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule // tb
